/* File: rtl/tda_map.vh */
// Constants for the telegraph distortion analyzer: register map, field
// positions, selector codes and timing figures.
// Assumes a 40 MHz aclk and 32-bit AXI4-Lite register access.
//
// Summary of operation
// - Code-level selector picks five-level start-stop, eight-level start-stop or synchronous.
// - Rate selector has thirteen internal rates 37.5 to 2400 baud plus external.
// - External rate setting times the analyzer from the external time-base input.
// - Transition selector measures one numbered transition 1..9, or all of them.
// - Kind selector measures mark-to-space only or space-to-mark only, among others.
// - Total peak mode keeps the largest early or late displacement until cleared.
// - Early peak keeps largest early displacement; late peak keeps largest late one.
// - Automatic clear zeroes all peak readings every five seconds.
// - While manual clear is held, peak readings are zeroed; it does not latch.
// - Marker enable inserts ideal-edge marks into the monitor copy of the signal.
// - Reversed polarity inverts the line signal, swapping mark and space.
// - Filter enable removes short transients; disabled passes the signal unchanged.
// - Fine time base runs at one hundred times the bit rate.
// - Distortion count runs 50 down to 0 and up to 50 per expected edge.
// - Mark-long on early space-to-mark or late mark-to-space; space-long otherwise.
`ifndef TDA_MAP_VH
`define TDA_MAP_VH

// ***************************************************************
// Register offsets (byte addresses)
// ***************************************************************
`define TDA_OFF_CTRL      4'h0
`define TDA_OFF_STATUS    4'h4
`define TDA_OFF_PEAK      4'h8

// ***************************************************************
// Control register fields
// ***************************************************************
`define TDA_CODE_LSB      0
`define TDA_CODE_MSB      1
`define TDA_RATE_LSB      4
`define TDA_RATE_MSB      7
`define TDA_TRAN_LSB      8
`define TDA_TRAN_MSB      11
`define TDA_KIND_LSB      12
`define TDA_KIND_MSB      14
`define TDA_AUTO_BIT      16
`define TDA_MAN_BIT       17
`define TDA_MARK_BIT      18
`define TDA_POL_BIT       19
`define TDA_FILT_BIT      20
`define TDA_CTRL_RESET    32'h0000_0000

// ***************************************************************
// Selector codes
// ***************************************************************
`define TDA_CODE_SS5      2'h0
`define TDA_CODE_SS8      2'h1
`define TDA_CODE_SYNC     2'h2
`define TDA_RATE_EXT      4'hd
`define TDA_TRAN_ALL      4'h0
`define TDA_KIND_END      3'h0
`define TDA_KIND_BIAS     3'h1
`define TDA_KIND_TOTAL    3'h2
`define TDA_KIND_EARLY    3'h3
`define TDA_KIND_LATE     3'h4

// ***************************************************************
// Timing
// ***************************************************************
`define TDA_CLK_HZ        40000000
`define TDA_AUTO_SEC      5
`define TDA_HALF_UI       7'h32
`define TDA_FILT_LEN      16'h0400
`define TDA_AXI_OKAY      2'h0
`define TDA_AXI_SLVERR    2'h2
`define TDA_UI_START      7'h00
`define TDA_LAST_SS5      4'h6
`define TDA_LAST_SS8      4'h9

// ***************************************************************
// Fine time-base dividers: aclk cycles per tick, rounded
// ***************************************************************
`define TDA_DIV_0         20'h029ab
`define TDA_DIV_1         20'h02257
`define TDA_DIV_2         20'h01f40
`define TDA_DIV_3         20'h01b82
`define TDA_DIV_4         20'h01993
`define TDA_DIV_5         20'h0150f
`define TDA_DIV_6         20'h014d5
`define TDA_DIV_7         20'h00e34
`define TDA_DIV_8         20'h00a6b
`define TDA_DIV_9         20'h00535
`define TDA_DIV_10        20'h0029b
`define TDA_DIV_11        20'h0014d
`define TDA_DIV_12        20'h000a7

`endif

/* File: rtl/tda_rate_rom.v */
// Rate table: fine time-base divider for each internal rate setting.
// Assumes the rate index is stable for a cycle; answer comes one cycle later.
`timescale 1ns/1ps
`include "tda_map.vh"

module tda_rate_rom (
	// Clock
	input  wire        aclk,
	input  wire        ce,
	// Lookup
	input  wire [3:0]  rate_idx,
	output reg  [19:0] div_reg
);

	// Cycles of aclk per fine tick = 40 MHz / (100 * baud); registered read
	always @(posedge aclk) begin
		if (ce) begin
			case (rate_idx)
				4'h0: div_reg <= `TDA_DIV_0; // 37.5
				4'h1: div_reg <= `TDA_DIV_1; // 45.5
				4'h2: div_reg <= `TDA_DIV_2; // 50
				4'h3: div_reg <= `TDA_DIV_3; // 56.8
				4'h4: div_reg <= `TDA_DIV_4; // 61.1
				4'h5: div_reg <= `TDA_DIV_5; // 74.2
				4'h6: div_reg <= `TDA_DIV_6; // 75
				4'h7: div_reg <= `TDA_DIV_7; // 110
				4'h8: div_reg <= `TDA_DIV_8; // 150
				4'h9: div_reg <= `TDA_DIV_9; // 300
				4'ha: div_reg <= `TDA_DIV_10; // 600
				4'hb: div_reg <= `TDA_DIV_11; // 1200
				4'hc: div_reg <= `TDA_DIV_12; // 2400
				default: div_reg <= `TDA_DIV_12;
			endcase
		end
	end

endmodule

/* File: rtl/tda_top.v */
// Distortion analyzer core: line conditioning, fine time base, distortion
// counter, peak hold, markers and an AXI4-Lite register slave.
// Assumes line and external time base are asynchronous pins.
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tda_map.vh"

module tda_top #(
	parameter AUTO_CYCLES = 200000000,
	parameter FILT_CYCLES = 1024
) (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	input  wire        ce,
	// Line and time base pins
	input  wire        line_in,
	input  wire        external_timebase_input,
	// Monitor and indicators
	output reg         monitor_out,
	output reg         mark_long,
	output reg         space_long,
	output reg  [5:0]  percent,
	output reg         late_flag,
	// AXI4-Lite write address
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read address
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);

	// ***************************************************************
	// Functions
	// ***************************************************************
	// Merge a write under byte enables; lanes with a clear strobe keep the old byte
	function [31:0] merge;
		input [31:0] old;
		input [31:0] dat;
		input [3:0]  stb;
		merge = old ^ ((old ^ dat) & {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}});
	endfunction

	// ***************************************************************
	// Registers
	// ***************************************************************
	reg  [31:0] ctrl_reg;
	reg  [1:0]  line_sync_reg;
	reg  [2:0]  ext_sync_reg;
	reg  [15:0] filt_cnt_reg;
	reg  [19:0] tick_cnt_reg;
	reg  [6:0]  dist_cnt_reg;
	reg  [3:0]  bit_idx_reg;
	reg  [5:0]  peak_reg;
	reg  [31:0] auto_cnt_reg;
	reg  [7:0]  marker_cnt_reg;
	reg  [3:0]  aw_addr_reg;
	reg  [31:0] w_data_reg;
	reg  [3:0]  w_strb_reg;
	reg         line_filt_reg, line_prev_reg, fine_timebase, ext_half_reg;
	reg         dist_down_reg, active_reg, peak_late_reg, aw_hold_reg, w_hold_reg;
	wire [19:0] rate_div;

	wire [1:0] code_sel  = ctrl_reg[`TDA_CODE_MSB:`TDA_CODE_LSB];
	wire [3:0] rate_sel  = ctrl_reg[`TDA_RATE_MSB:`TDA_RATE_LSB];
	wire [3:0] tran_sel  = ctrl_reg[`TDA_TRAN_MSB:`TDA_TRAN_LSB];
	wire [2:0] kind_sel  = ctrl_reg[`TDA_KIND_MSB:`TDA_KIND_LSB];
	wire       ext_mode  = (rate_sel == `TDA_RATE_EXT);
	wire [3:0] last_bit  = (code_sel == `TDA_CODE_SS8) ? `TDA_LAST_SS8 : `TDA_LAST_SS5;
	// Rate lookup lives in its own registered table
	tda_rate_rom u_rate (
		.aclk     (aclk),
		.ce       (ce),
		.rate_idx (rate_sel),
		.div_reg  (rate_div)
	);

	// ***************************************************************
	// Line conditioning
	// ***************************************************************
	// Two-stage synchronisers; polarity swap after sync
	always @(posedge aclk) begin
		if (!aresetn) begin
			line_sync_reg <= 2'h0;
			ext_sync_reg  <= 3'h0;
		end else if (ce) begin
			line_sync_reg <= {line_sync_reg[0], line_in};
			ext_sync_reg  <= {ext_sync_reg[1:0], external_timebase_input};
		end
	end

	wire line_pol = line_sync_reg[1] ^ ctrl_reg[`TDA_POL_BIT];
	// Glitch filter: a level must persist FILT_CYCLES before it is accepted
	always @(posedge aclk) begin
		if (!aresetn) begin
			line_filt_reg <= 1'b1;
			filt_cnt_reg  <= 16'h0;
		end else if (ce) begin
			if (!ctrl_reg[`TDA_FILT_BIT]) begin
				line_filt_reg <= line_pol;
				filt_cnt_reg  <= 16'h0;
			end else if (line_pol == line_filt_reg) begin
				filt_cnt_reg <= 16'h0;
			end else if (filt_cnt_reg == FILT_CYCLES[15:0] - 16'h1) begin
				line_filt_reg <= line_pol;
				filt_cnt_reg  <= 16'h0;
			end else begin
				filt_cnt_reg <= filt_cnt_reg + 16'h1;
			end
		end
	end

	// ***************************************************************
	// Fine time base
	// ***************************************************************
	// External clock is 200x baud, so every second rising edge is one fine tick
	wire ext_rise  = ext_sync_reg[1] & ~ext_sync_reg[2];
	wire int_tick  = (tick_cnt_reg >= rate_div - 20'h1);
	wire line_edge = (line_filt_reg != line_prev_reg);
	wire start_bit = !active_reg && line_edge && !line_filt_reg;
	wire sync_mode = (code_sel == `TDA_CODE_SYNC);
	// Both dividers restart on each start edge so ticks line up with the start element
	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_reg  <= 20'h0;
			fine_timebase <= 1'b0;
			ext_half_reg  <= 1'b0;
		end else if (ce) begin
			fine_timebase <= 1'b0;
			if (ext_mode) begin
				tick_cnt_reg  <= 20'h0;
				ext_half_reg  <= !start_bit && (ext_half_reg ^ ext_rise);
				fine_timebase <= ext_rise && ext_half_reg && !start_bit;
			end else if (start_bit || int_tick) begin
				tick_cnt_reg  <= 20'h0;
				fine_timebase <= int_tick && !start_bit;
			end else begin
				tick_cnt_reg <= tick_cnt_reg + 20'h1;
			end
		end
	end

	// ***************************************************************
	// Distortion counter and bit tracking
	// ***************************************************************
	// Start edge loads zero counting up, so every ideal edge later falls on a zero count
	always @(posedge aclk) begin
		if (!aresetn) begin
			dist_cnt_reg  <= `TDA_HALF_UI;
			dist_down_reg <= 1'b1;
			bit_idx_reg   <= 4'h0;
			active_reg    <= 1'b0;
			line_prev_reg <= 1'b1;
		end else if (ce) begin
			line_prev_reg <= line_filt_reg;
			if (start_bit && !sync_mode) begin
				dist_cnt_reg  <= `TDA_UI_START;
				dist_down_reg <= 1'b0;
				bit_idx_reg   <= 4'h0;
				active_reg    <= 1'b1;
			end else if (fine_timebase && (active_reg || sync_mode)) begin
				if (dist_down_reg) begin
					dist_cnt_reg <= dist_cnt_reg - 7'h1;
					if (dist_cnt_reg == 7'h1)
						dist_down_reg <= 1'b0;
				end else if (dist_cnt_reg == `TDA_HALF_UI) begin
					dist_down_reg <= 1'b1;
					dist_cnt_reg  <= `TDA_HALF_UI - 7'h1;
					bit_idx_reg   <= bit_idx_reg + 4'h1;
					if (!sync_mode && bit_idx_reg == last_bit)
						active_reg <= 1'b0;
				end else begin
					dist_cnt_reg <= dist_cnt_reg + 7'h1;
				end
			end
		end
	end

	// ***************************************************************
	// Capture, classification and peak hold
	// ***************************************************************
	wire to_space = line_edge && !line_filt_reg;
	wire to_mark  = line_edge && line_filt_reg;
	wire is_late  = !dist_down_reg;
	wire tran_ok  = (tran_sel == `TDA_TRAN_ALL) || (tran_sel == bit_idx_reg);
	wire kind_ok  = (kind_sel == `TDA_KIND_END)   ? to_space :
	                (kind_sel == `TDA_KIND_BIAS)  ? to_mark  :
	                (kind_sel == `TDA_KIND_EARLY) ? !is_late :
	                (kind_sel == `TDA_KIND_LATE)  ? is_late  : 1'b1;
	wire capture  = line_edge && (active_reg || sync_mode) && !start_bit && tran_ok && kind_ok;
	wire peak_mode = (kind_sel == `TDA_KIND_TOTAL) || (kind_sel == `TDA_KIND_EARLY) || (kind_sel == `TDA_KIND_LATE);
	wire auto_tick = (auto_cnt_reg == AUTO_CYCLES - 1);
	wire clear_pk  = ctrl_reg[`TDA_MAN_BIT] || (ctrl_reg[`TDA_AUTO_BIT] && auto_tick);

	// Free-running five-second divider, independent of rate
	always @(posedge aclk) begin
		if (!aresetn)
			auto_cnt_reg <= 32'h0;
		else if (ce)
			auto_cnt_reg <= auto_tick ? 32'h0 : auto_cnt_reg + 32'h1;
	end

	// Peak hold; a capture in the clear cycle still lands on the zeroed value
	always @(posedge aclk) begin
		if (!aresetn) begin
			peak_reg      <= 6'h0;
			peak_late_reg <= 1'b0;
		end else if (ce) begin
			if (capture && (!peak_mode || clear_pk || dist_cnt_reg[5:0] > peak_reg)) begin
				peak_reg      <= dist_cnt_reg[5:0];
				peak_late_reg <= is_late;
			end else if (clear_pk && peak_mode) begin
				peak_reg      <= 6'h0;
				peak_late_reg <= 1'b0;
			end
		end
	end

	// Display outputs and mark/space-long lamps
	always @(posedge aclk) begin
		if (!aresetn) begin
			percent    <= 6'h0;
			late_flag  <= 1'b0;
			mark_long  <= 1'b0;
			space_long <= 1'b0;
		end else if (ce) begin
			percent   <= peak_reg;
			late_flag <= peak_late_reg;
			if (capture) begin
				mark_long  <= (to_mark && !is_late) || (to_space && is_late);
				space_long <= (to_mark && is_late) || (to_space && !is_late);
			end
		end
	end

	// ***************************************************************
	// Monitor output with ideal-edge markers
	// ***************************************************************
	// Marker pulse is a short inversion at each count-zero instant
	always @(posedge aclk) begin
		if (!aresetn) begin
			marker_cnt_reg <= 8'h0;
			monitor_out    <= 1'b1;
		end else if (ce) begin
			if (ctrl_reg[`TDA_MARK_BIT] && fine_timebase && dist_cnt_reg == 7'h1 && dist_down_reg)
				marker_cnt_reg <= 8'hff;
			else if (marker_cnt_reg != 8'h0)
				marker_cnt_reg <= marker_cnt_reg - 8'h1;
			monitor_out <= line_filt_reg ^ (marker_cnt_reg != 8'h0);
		end
	end

	// ***************************************************************
	// AXI4-Lite slave
	// ***************************************************************
	// Address and data taken independently; response once both held
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg      <= `TDA_CTRL_RESET;
			aw_hold_reg   <= 1'b0;
			w_hold_reg    <= 1'b0;
			aw_addr_reg   <= 4'h0;
			w_data_reg    <= 32'h0;
			w_strb_reg    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TDA_AXI_OKAY;
		end else if (ce) begin
			s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_hold_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
				aw_hold_reg  <= 1'b0;
				w_hold_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (aw_addr_reg == `TDA_OFF_CTRL) begin
					ctrl_reg    <= merge(ctrl_reg, w_data_reg, w_strb_reg);
					s_axi_bresp <= `TDA_AXI_OKAY;
				end else begin
					s_axi_bresp <= `TDA_AXI_SLVERR;
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Reads: status shows live tracking state, peak shows held reading
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= `TDA_AXI_OKAY;
		end else if (ce) begin
			s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `TDA_AXI_OKAY;
				case (s_axi_araddr)
					`TDA_OFF_CTRL:   s_axi_rdata <= ctrl_reg;
					`TDA_OFF_STATUS: s_axi_rdata <= {20'h0, bit_idx_reg, space_long, mark_long,
					                                 active_reg, line_filt_reg, 4'h0};
					`TDA_OFF_PEAK:   s_axi_rdata <= {23'h0, peak_late_reg, 2'h0, peak_reg};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= `TDA_AXI_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

/* File: tb/tda_top_asserts.sv */
// Checker for the analyzer top: bus handshakes and indicator outputs.
// Assumes ce is held high; bound to the top from the bench file.
`timescale 1ns/1ps
`include "tda_map.vh"
module tda_top_asserts (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Indicators
	input logic        mark_long,
	input logic        space_long,
	input logic [5:0]  percent,
	// Register bus
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic        s_axi_wvalid,
	input logic        s_axi_wready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready
);
	// ***************************************************************
	// Properties
	// ***************************************************************
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write channels taken at one edge; the slave can also take them at different edges
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
		else $error("write response missing");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read data missing");
	// A response must not vanish or change before the master takes it
	a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken during response");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during response");
	a_percent_range: assert property (percent <= `TDA_HALF_UI)
		else $error("percent above half interval");
	a_lamps_apart: assert property (!(mark_long && space_long))
		else $error("both lamps lit");
endmodule

/* File: tb/tda_line_model.sv */
// Line under test and external time base for the analyzer bench.
// Assumes 5-level start-stop characters; a fine tick is two generator periods.
`timescale 1ns/1ps
module tda_line_model (
	// Pins toward the analyzer
	output logic line_in,
	output logic external_timebase_input
);
	logic pol = 0;
	initial line_in = 1;
	initial external_timebase_input = 0;
	// Square wave at 200 times the baud rate, free running like a lab generator
	always #50 external_timebase_input = ~external_timebase_input;
	task wt(input int n);
		repeat (2 * n) @(posedge external_timebase_input);
	endtask
	// One character: start element, one edge shifted by d ticks, then mark
	task send(input int d);
		@(posedge external_timebase_input);
		line_in = pol;
		wt(100 - d);
		line_in = !pol;
		wt(800 + d);
	endtask
	task flip(input logic p);
		pol = p;
		line_in = !p;
	endtask
	// Short spike toward space, well under the filter length
	task glitch;
		line_in = pol;
		#60;
		line_in = !pol;
	endtask
endmodule

/* File: tb/tda_top_tb_top.sv */
// Bench for the analyzer: register access over AXI4-Lite and measurements
// of single characters. Assumes the map header is on the include path.
`timescale 1ns/1ps
`include "tda_map.vh"
module tda_top_tb_top;
	logic        aclk = 0, aresetn = 0, ce = 1;
	logic        line_in, external_timebase_input, monitor_out, mark_long, space_long, late_flag;
	logic [5:0]  percent;
	logic [3:0]  s_axi_awaddr = 0, s_axi_wstrb = 4'hf, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          n_mismatch = 0, tests_run = 0, mon_cnt = 0, m0, k;

	tda_top #(.AUTO_CYCLES(3000), .FILT_CYCLES(4)) dut (.*);
	tda_line_model u_line (.line_in(line_in), .external_timebase_input(external_timebase_input));

	// 40 MHz clock
	always #12.5 aclk = ~aclk;
	// Cycles where the monitor copy differs from the pin
	always @(posedge aclk) if (monitor_out !== line_in) mon_cnt <= mon_cnt + 1;

	// ***************************************************************
	// Tasks
	// ***************************************************************
	task test_done;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	// Bounded waits end the run rather than hang
	task quit(input int i);
		if (i > 3000) begin
			n_mismatch++;
			$display("unexpected bus wait: expected answer seen none");
			test_done;
		end
	endtask
	function logic near(input int s, input int e);
		return s + 2 >= e && s <= e + 2;
	endfunction
	// Response ready is raised late on purpose so the slave must hold it
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
		int i;
		i = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			quit(i++);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
		repeat (3) @(posedge aclk);
		s_axi_bready <= 1;
		do begin @(posedge aclk); quit(i++); end while (!s_axi_bvalid);
		s_axi_bready <= 0;
		chk("bresp", s_axi_bresp, e);
	endtask
	task rd(input logic [3:0] a);
		int i;
		i = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do begin @(posedge aclk); quit(i++); end while (!s_axi_arready);
		s_axi_arvalid <= 0;
		repeat (2) @(posedge aclk);
		s_axi_rready <= 1;
		do begin @(posedge aclk); quit(i++); end while (!s_axi_rvalid);
		rdat = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	// Control word: 5-level code, external time base
	task ctl(input logic [2:0] kd, input logic [3:0] t, input logic [31:0] f);
		wr(`TDA_OFF_CTRL, f | {17'h0, kd, t, `TDA_RATE_EXT, 4'h0}, `TDA_AXI_OKAY);
	endtask
	task clr(input logic [2:0] kd, input logic [3:0] t, input logic [31:0] f);
		ctl(kd, t, f | 32'h1 << `TDA_MAN_BIT);
		ctl(kd, t, f);
	endtask
	task pk(input int p, input logic l);
		rd(`TDA_OFF_PEAK);
		chk("peak", p == 0 ? rdat[5:0] == 0 : near(rdat[5:0], p), 1);
		chk("peak late", rdat[8], l);
	endtask
	task snd(input int d);
		u_line.send(d);
		@(posedge aclk);
	endtask

	// ***************************************************************
	// Sequence
	// ***************************************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(`TDA_OFF_CTRL);
		chk("ctrl reset", rdat, `TDA_CTRL_RESET);
		rd(4'hc);
		chk("unmapped resp", resp, `TDA_AXI_SLVERR);
		chk("unmapped data", rdat, 0);
		wr(4'hc, 32'hffff_ffff, `TDA_AXI_SLVERR);
		// Every code and kind, five of the rates and a spread of transitions
		for (k = 0; k < 5; k++) begin
			wr(`TDA_OFF_CTRL, k * 32'h1130 + k % 3, `TDA_AXI_OKAY);
			rd(`TDA_OFF_CTRL);
			chk("ctrl", rdat, k * 32'h1130 + k % 3);
		end
		// Early space-to-mark edge with markers on
		ctl(`TDA_KIND_BIAS, `TDA_TRAN_ALL, 32'h1 << `TDA_MARK_BIT);
		m0 = mon_cnt;
		snd(12);
		chk("percent", near(percent, 12), 1);
		chk("late flag", late_flag, 0);
		chk("mark long", mark_long, 1);
		chk("space long", space_long, 0);
		chk("markers", mon_cnt - m0 > 200, 1);
		// Peak holds the larger one, early or late
		clr(`TDA_KIND_TOTAL, `TDA_TRAN_ALL, 0);
		pk(0, 0);
		m0 = mon_cnt;
		snd(20);
		snd(-6);
		pk(20, 0);
		chk("no markers", mon_cnt - m0 > 200, 0);
		// Auto clear within one interval
		ctl(`TDA_KIND_TOTAL, `TDA_TRAN_ALL, 32'h1 << `TDA_AUTO_BIT);
		repeat (3100) @(posedge aclk);
		pk(0, 0);
		// Only edge lies at transition 1, so transition 2 sees nothing
		clr(`TDA_KIND_TOTAL, 4'h2, 0);
		snd(10);
		pk(0, 0);
		// Early peak under reversed polarity ignores a late edge
		ctl(`TDA_KIND_EARLY, `TDA_TRAN_ALL, 32'h1 << `TDA_POL_BIT);
		u_line.flip(1);
		repeat (7000) @(posedge aclk);
		clr(`TDA_KIND_EARLY, `TDA_TRAN_ALL, 32'h1 << `TDA_POL_BIT);
		snd(-15);
		pk(0, 0);
		snd(8);
		pk(8, 0);
		// Late peak ignores a larger early edge
		u_line.flip(0);
		ctl(`TDA_KIND_LATE, `TDA_TRAN_ALL, 0);
		repeat (7000) @(posedge aclk);
		clr(`TDA_KIND_LATE, `TDA_TRAN_ALL, 0);
		snd(20);
		snd(-9);
		pk(9, 1);
		// A spike starts a character only when the filter is out
		ctl(`TDA_KIND_END, `TDA_TRAN_ALL, 32'h1 << `TDA_FILT_BIT);
		u_line.glitch;
		@(posedge aclk);
		rd(`TDA_OFF_STATUS);
		chk("filtered spike", rdat[5], 0);
		ctl(`TDA_KIND_END, `TDA_TRAN_ALL, 0);
		u_line.glitch;
		@(posedge aclk);
		rd(`TDA_OFF_STATUS);
		chk("raw spike", rdat[5], 1);
		test_done;
	end
endmodule

bind tda_top tda_top_asserts u_chk (.*);
